//--- tcsup_pkg.sv
// Constants, register map and carrier types of the temperature controller supervisor.
// Assumes a single 20 MHz clock and temperatures in signed tenths of a degree.
`default_nettype none
package tcsup_pkg;
  // Register byte offsets
  localparam logic [7:0] A_SP = 8'h00;
  localparam logic [7:0] A_BAND = 8'h04;
  localparam logic [7:0] A_MODE = 8'h08;
  localparam logic [7:0] A_GAIN = 8'h0c;
  localparam logic [7:0] A_ILIM = 8'h10;
  localparam logic [7:0] A_DUTY = 8'h14;
  localparam logic [7:0] A_OFFS = 8'h18;
  localparam logic [7:0] A_RAMP = 8'h1c;
  localparam logic [7:0] A_CTRL = 8'h20;
  localparam logic [7:0] A_STAT = 8'h24;
  localparam logic [7:0] A_DISP = 8'h28;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  // Limits; set point, range and band in tenths of a degree
  localparam logic signed [15:0] SP_MIN = -16'sd990;
  localparam logic signed [15:0] SP_MAX = 16'sd1999;
  localparam logic signed [15:0] ORNG_LO = -16'sd750;
  localparam logic signed [15:0] ORNG_HI = 16'sd1750;
  localparam logic [7:0] BAND_MAX = 8'h63;
  localparam logic [1:0] SENS_MAX = 2'h2;
  localparam logic [7:0] GAIN_MAX = 8'h3f;
  localparam logic [15:0] ILIM_MAX = 16'h03e7;
  localparam logic [15:0] DUTY_MAX = 16'h007f;
  localparam logic [15:0] RAMP_MAX = 16'h03e7;
  // Timing
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned ERR_SHOW_S = 5;
  localparam int unsigned RAMP_UNIT_S = 60;
  // Display codes, BCD
  localparam logic [15:0] CODE_ORNG = 16'h9999;
  localparam logic [15:0] CODE_E100 = 16'h0100;
  localparam logic [15:0] CODE_E200 = 16'h0200;
  localparam int NF_N = 5;
  // Reset values
  localparam logic [5:0] FILT_RST = 6'h01;
  localparam logic [6:0] DUTY_RST = 7'h7f;

  typedef enum logic [1:0] {
    ST_INIT = 2'b00, ST_RUN = 2'b01, ST_ORNG = 2'b11, ST_FATAL = 2'b10
  } tcsup_state_t;
  typedef enum logic [1:0] {
    DM_TEST = 2'h0, DM_TEMP = 2'h1, DM_ERR = 2'h2, DM_ORNG = 2'h3
  } tcsup_dmode_t;

  typedef struct packed {
    logic signed [15:0] setpoint;
    logic [6:0] tol_band;
    logic [6:0] alarm_band;
    logic [5:0] filt_sec;
    logic [1:0] sensor_choice_item;
    logic aux_in_on;
    logic alarm_output_mode;
    logic [5:0] proportional_gain;
    logic [5:0] integral_gain;
    logic [5:0] derivative_gain;
    logic [9:0] integrator_limit;
    logic [6:0] duty_limit;
    logic signed [15:0] offset;
    logic [9:0] ramp_rate;
  } tcsup_cfg_t;

  typedef struct packed {
    tcsup_dmode_t mode;
    logic [15:0] code;
    logic blink;
  } tcsup_disp_t;
endpackage : tcsup_pkg
`default_nettype wire

//--- tcsup_top.sv
// Supervisor of a thermoelectric temperature controller: configuration store,
// set point ramp, over-range and error handling, AXI4-Lite register slave.
// Assumes synchronous inputs, a loop and display driver that use its outputs.
`default_nettype none
module tcsup_top
  import tcsup_pkg::*;
#(
  parameter int unsigned ERR_SHOW_CYC = ERR_SHOW_S * CLK_HZ,
  parameter int unsigned RAMP_UNIT_CYC = RAMP_UNIT_S * CLK_HZ
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Measurement
  input wire logic temp_valid,
  input wire logic signed [15:0] temp_raw,
  // Stored configuration
  input wire logic cfg_load_done,
  input wire logic cfg_load_ok,
  input wire tcsup_cfg_t cfg_load,
  // Operator keys
  input wire logic key_wr,
  input wire logic [7:0] key_addr,
  input wire logic [31:0] key_val,
  // Aux input and faults
  input wire logic aux_in,
  input wire logic [NF_N-1:0] fault_pulse,
  input wire logic stack_fault,
  // Results
  output tcsup_cfg_t cfg_eff,
  output logic signed [15:0] active_sp,
  output logic power_en,
  output logic aux_out,
  output tcsup_disp_t disp
);

  if (ERR_SHOW_CYC < 1 || RAMP_UNIT_CYC < 1 || RAMP_UNIT_CYC > 32'h7fffffff) begin : g_chk
    $error("tcsup_top: timing parameter out of range");
  end

  tcsup_cfg_t shadow_reg, shadow_next, eff_next;
  tcsup_state_t state_reg;
  logic aw_full_reg, w_full_reg, ar_take, aw_take, w_take, do_write;
  logic [7:0] waddr_reg;
  logic [31:0] wdata_reg, wold, wval;
  logic [3:0] wstrb_reg;
  logic is_cfg_w, apply;
  logic signed [15:0] pv_reg;
  logic sp_seeded_reg, orng, in_err;
  logic [31:0] ramp_acc_reg, err_tmr_reg;
  logic [15:0] nf_code_reg;
  logic signed [16:0] dev;
  logic [16:0] dev_abs;
  logic ctl_on;
  logic [15:0] fatal_code_reg;

  function automatic logic is_cfg(input logic [7:0] a);
    return a == A_SP || a == A_BAND || a == A_MODE || a == A_GAIN ||
           a == A_ILIM || a == A_DUTY || a == A_OFFS || a == A_RAMP;
  endfunction : is_cfg

  function automatic logic [31:0] cfg_get(input tcsup_cfg_t c, input logic [7:0] a);
    logic [31:0] r;
    r = 32'h0;
    case (a)
      A_SP: r = {{16{c.setpoint[15]}}, c.setpoint};
      A_BAND: r = {16'h0, 1'b0, c.alarm_band, 1'b0, c.tol_band};
      A_MODE: r = {14'h0, c.alarm_output_mode, c.aux_in_on, 6'h0,
                   c.sensor_choice_item, 2'h0, c.filt_sec};
      A_GAIN: r = {10'h0, c.derivative_gain, 2'h0, c.integral_gain, 2'h0,
                   c.proportional_gain};
      A_ILIM: r = {22'h0, c.integrator_limit};
      A_DUTY: r = {25'h0, c.duty_limit};
      A_OFFS: r = {{16{c.offset[15]}}, c.offset};
      A_RAMP: r = {22'h0, c.ramp_rate};
      default: r = 32'h0;
    endcase
    return r;
  endfunction : cfg_get

  // Range checked store of one configuration word
  function automatic tcsup_cfg_t cfg_put(input tcsup_cfg_t c, input logic [7:0] a,
                                         input logic [31:0] v,
                                         input logic signed [15:0] raw,
                                         input logic from_key);
    tcsup_cfg_t r;
    logic signed [15:0] s;
    logic signed [15:0] d;
    r = c;
    s = v[15:0];
    d = s - raw;
    case (a)
      A_SP: if (s >= SP_MIN && s <= SP_MAX) r.setpoint = s;
      A_BAND: begin
        if (v[7:0] <= BAND_MAX) r.tol_band = v[6:0];
        if (v[15:8] <= BAND_MAX) r.alarm_band = v[14:8];
      end
      A_MODE: begin
        case (v[7:0])
          8'h01, 8'h02, 8'h05, 8'h0a, 8'h14, 8'h32: r.filt_sec = v[5:0];
          default: ;
        endcase
        if (v[15:10] == 6'h0 && v[9:8] <= SENS_MAX) r.sensor_choice_item = v[9:8];
        r.aux_in_on = v[16];
        r.alarm_output_mode = v[17];
      end
      A_GAIN: begin
        r.proportional_gain = (v[7:0] > GAIN_MAX) ? GAIN_MAX[5:0] : v[5:0];
        r.integral_gain = (v[15:8] > GAIN_MAX) ? GAIN_MAX[5:0] : v[13:8];
        r.derivative_gain = (v[23:16] > GAIN_MAX) ? GAIN_MAX[5:0] : v[21:16];
      end
      A_ILIM: r.integrator_limit = (v[15:0] > ILIM_MAX) ? ILIM_MAX[9:0] : v[9:0];
      A_DUTY: r.duty_limit = (v[15:0] > DUTY_MAX) ? 7'h0 : v[6:0];
      A_OFFS: begin
        if (!from_key) r.offset = s;
        else if (d != 16'sh0) r.offset = d;
      end
      A_RAMP: if (v[15:0] <= RAMP_MAX) r.ramp_rate = v[9:0];
      default: ;
    endcase
    return r;
  endfunction : cfg_put

  // AXI4-Lite slave
  assign aw_take = awvalid & awready;
  assign w_take = wvalid & wready;
  assign ar_take = arvalid & arready;
  assign do_write = aw_full_reg & w_full_reg & ~bvalid;
  assign wold = cfg_get(shadow_reg, waddr_reg);
  for (genvar i = 0; i < 4; i++) begin : g_lane
    assign wval[8*i +: 8] = wstrb_reg[i] ? wdata_reg[8*i +: 8] : wold[8*i +: 8];
  end
  assign is_cfg_w = do_write & is_cfg(waddr_reg);
  assign apply = do_write & (waddr_reg == A_CTRL) & wstrb_reg[0] & wdata_reg[0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= RESP_OK;
      waddr_reg <= 8'h0;
      wdata_reg <= 32'h0;
      wstrb_reg <= 4'h0;
    end else begin
      if (aw_take) waddr_reg <= awaddr;
      if (w_take) begin
        wdata_reg <= wdata;
        wstrb_reg <= wstrb;
      end
      aw_full_reg <= (aw_full_reg | aw_take) & ~do_write;
      w_full_reg <= (w_full_reg | w_take) & ~do_write;
      awready <= ~(aw_full_reg | aw_take) & ~do_write & ~(bvalid & ~bready);
      wready <= ~(w_full_reg | w_take) & ~do_write & ~(bvalid & ~bready);
      if (do_write) begin
        bvalid <= 1'b1;
        bresp <= (is_cfg(waddr_reg) || waddr_reg == A_CTRL) ? RESP_OK : RESP_ERR;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= RESP_OK;
    end else begin
      arready <= ~ar_take & ~(rvalid & ~rready);
      if (ar_take) begin
        rvalid <= 1'b1;
        rresp <= RESP_OK;
        if (is_cfg(araddr)) rdata <= cfg_get(shadow_reg, araddr);
        else if (araddr == A_CTRL) rdata <= 32'h0;
        else if (araddr == A_STAT)
          rdata <= {active_sp, 8'h0, aux_out, power_en, sp_seeded_reg, orng,
                    2'h0, state_reg};
        else if (araddr == A_DISP) rdata <= {13'h0, disp.blink, disp.mode, disp.code};
        else begin
          rdata <= 32'h0;
          rresp <= RESP_ERR;
        end
      end else if (rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // Configuration: host edits wait in the shadow, keys act at once unless an apply or the stored load falls in the same cycle
  always_comb begin
    shadow_next = shadow_reg;
    eff_next = cfg_eff;
    if (key_wr) begin
      shadow_next = cfg_put(shadow_next, key_addr, key_val, temp_raw, 1'b1);
      eff_next = cfg_put(cfg_eff, key_addr, key_val, temp_raw, 1'b1);
    end
    if (is_cfg_w) shadow_next = cfg_put(shadow_next, waddr_reg, wval, temp_raw, 1'b0);
    if (apply) eff_next = shadow_reg;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      shadow_reg <= '0;
      cfg_eff <= '0;
      shadow_reg.filt_sec <= FILT_RST;
      cfg_eff.filt_sec <= FILT_RST;
      shadow_reg.duty_limit <= DUTY_RST;
      cfg_eff.duty_limit <= DUTY_RST;
    end else if (state_reg == ST_INIT && cfg_load_done && cfg_load_ok) begin
      shadow_reg <= cfg_load;
      cfg_eff <= cfg_load;
    end else begin
      shadow_reg <= shadow_next;
      cfg_eff <= eff_next;
    end
  end

  // Measurement and over-range
  always_ff @(posedge aclk) begin
    if (!aresetn) pv_reg <= 16'sh0;
    else if (temp_valid) pv_reg <= temp_raw + cfg_eff.offset;
  end
  assign orng = (pv_reg < ORNG_LO) || (pv_reg > ORNG_HI);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= ST_INIT;
    end else begin
      case (state_reg)
        ST_INIT: if (stack_fault || (cfg_load_done && !cfg_load_ok)) state_reg <= ST_FATAL;
          else if (cfg_load_done) state_reg <= ST_RUN;
        ST_RUN: if (stack_fault) state_reg <= ST_FATAL;
          else if (orng) state_reg <= ST_ORNG;
        ST_ORNG: if (stack_fault) state_reg <= ST_FATAL;
          else if (!orng) state_reg <= ST_RUN;
        ST_FATAL: state_reg <= ST_FATAL;
        default: state_reg <= ST_INIT;
      endcase
    end
  end

  // Fatal cause is frozen on entry so a later load flag change cannot alter the code
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fatal_code_reg <= CODE_E100;
    end else if (state_reg != ST_FATAL) begin
      fatal_code_reg <= stack_fault ? CODE_E200 : CODE_E100;
    end
  end

  // Non-fatal error: lowest code wins, shown for a fixed time
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      err_tmr_reg <= 32'h0;
      nf_code_reg <= 16'h0;
    end else if (fault_pulse != '0) begin
      err_tmr_reg <= ERR_SHOW_CYC;
      for (int i = NF_N - 1; i >= 0; i--) begin
        if (fault_pulse[i]) nf_code_reg <= 16'(i + 1);
      end
    end else if (err_tmr_reg != 32'h0) begin
      err_tmr_reg <= err_tmr_reg - 32'h1;
    end
  end
  assign in_err = err_tmr_reg != 32'h0;

  // Active set point ramp
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sp_seeded_reg <= 1'b0;
      active_sp <= 16'sh0;
      ramp_acc_reg <= 32'h0;
    end else if (!sp_seeded_reg) begin
      if (state_reg == ST_RUN && temp_valid) begin
        active_sp <= temp_raw + cfg_eff.offset;
        sp_seeded_reg <= 1'b1;
      end
    end else if (cfg_eff.ramp_rate == 10'h0) begin
      active_sp <= cfg_eff.setpoint;
      ramp_acc_reg <= 32'h0;
    end else if (active_sp == cfg_eff.setpoint) begin
      ramp_acc_reg <= 32'h0;
    end else if (ramp_acc_reg + 32'(cfg_eff.ramp_rate) >= RAMP_UNIT_CYC) begin
      ramp_acc_reg <= ramp_acc_reg + 32'(cfg_eff.ramp_rate) - RAMP_UNIT_CYC;
      active_sp <= (active_sp < cfg_eff.setpoint) ? active_sp + 16'sh1 : active_sp - 16'sh1;
    end else begin
      ramp_acc_reg <= ramp_acc_reg + 32'(cfg_eff.ramp_rate);
    end
  end

  // Outputs
  assign dev = 17'(pv_reg) - 17'(active_sp);
  assign dev_abs = dev[16] ? 17'(-dev) : 17'(dev);
  assign ctl_on = cfg_eff.aux_in_on ? aux_in : ~aux_in;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      power_en <= 1'b0;
      aux_out <= 1'b0;
    end else if (state_reg != ST_RUN || orng || in_err || !sp_seeded_reg) begin
      power_en <= 1'b0;
      aux_out <= 1'b0;
    end else begin
      power_en <= ctl_on && cfg_eff.duty_limit != 7'h0;
      if (!cfg_eff.alarm_output_mode) aux_out <= dev_abs > 17'(cfg_eff.alarm_band);
      else aux_out <= dev_abs <= 17'(cfg_eff.tol_band);
    end
  end

  // Display, independent of bus traffic
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      disp <= '{mode: DM_TEST, code: 16'h0, blink: 1'b0};
    end else begin
      case (state_reg)
        ST_INIT: disp <= '{mode: DM_TEST, code: 16'h0, blink: 1'b0};
        ST_FATAL: disp <= '{mode: DM_ERR, code: fatal_code_reg, blink: 1'b0};
        ST_ORNG: disp <= '{mode: DM_ORNG, code: CODE_ORNG, blink: 1'b1};
        default: if (in_err) disp <= '{mode: DM_ERR, code: nf_code_reg, blink: 1'b0};
          else disp <= '{mode: DM_TEMP, code: pv_reg, blink: 1'b0};
      endcase
    end
  end

endmodule : tcsup_top
`default_nettype wire

//--- tcsup_monitor.sv
// Checker of the temperature controller supervisor, watching top-level ports only.
// Assumes it is bound into tcsup_top and sees the outputs as registered there.
`default_nettype none
module tcsup_monitor
  import tcsup_pkg::*;
#(
  parameter int unsigned ERR_SHOW_CYC = ERR_SHOW_S * CLK_HZ,
  parameter int unsigned RAMP_UNIT_CYC = RAMP_UNIT_S * CLK_HZ
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bus answers
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  // Measurement and events
  input wire logic temp_valid,
  input wire logic signed [15:0] temp_raw,
  input wire logic aux_in,
  input wire logic [NF_N-1:0] fault_pulse,
  // Results
  input wire tcsup_cfg_t cfg_eff,
  input wire logic power_en,
  input wire logic aux_out,
  input wire tcsup_disp_t disp
);
  timeunit 1ns;
  timeprecision 1ns;
  logic signed [15:0] pv_now;
  logic [31:0] err_cnt;
  assign pv_now = temp_raw + cfg_eff.offset;
  // Length of the current non-fatal code display
  always_ff @(posedge aclk) begin
    if (!aresetn || disp.mode != DM_ERR || disp.code > 16'h0005) begin
      err_cnt <= 32'h0;
    end else begin
      err_cnt <= err_cnt + 32'h1;
    end
  end
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  a_orng_entry: assert property (
    (temp_valid && disp.mode == DM_TEMP && (pv_now > ORNG_HI || pv_now < ORNG_LO))
    |-> ##[1:3] (disp.code == CODE_ORNG && disp.blink)) else $error("over-range not shown");
  a_orng_leave: assert property (
    (temp_valid && disp.mode == DM_ORNG && pv_now <= ORNG_HI && pv_now >= ORNG_LO)
    |-> ##[1:3] (disp.mode != DM_ORNG)) else $error("over-range not left");
  a_orng_quiet: assert property (
    (disp.mode == DM_ORNG) [*2] |-> !power_en && !aux_out) else $error("outputs on in over-range");
  a_init_quiet: assert property (
    disp.mode == DM_TEST |-> !power_en && !aux_out) else $error("outputs on during init");
  a_duty_off: assert property (
    (cfg_eff.duty_limit == 7'h00) [*2] |-> !power_en) else $error("power on with zero duty");
  a_auxin_gate: assert property (
    (aux_in != cfg_eff.aux_in_on) [*2] |-> !power_en) else $error("aux input did not gate power");
  a_cfg_range: assert property (
    cfg_eff.setpoint >= SP_MIN && cfg_eff.setpoint <= SP_MAX && cfg_eff.tol_band <= 7'h63
    && cfg_eff.alarm_band <= 7'h63 && cfg_eff.sensor_choice_item <= SENS_MAX
    && cfg_eff.integrator_limit <= 10'h3e7) else $error("effective value out of range");
  a_filt_set: assert property (
    cfg_eff.filt_sec inside {6'h01, 6'h02, 6'h05, 6'h0a, 6'h14, 6'h32})
    else $error("filter value not selectable");
  a_fault_code: assert property (
    (fault_pulse != '0 && disp.mode == DM_TEMP) |-> ##[1:2] (disp.mode == DM_ERR
    && !disp.blink && disp.code >= 16'h0001 && disp.code <= 16'h0005)) else $error("no fault code");
  a_err_bounded: assert property (
    err_cnt <= ERR_SHOW_CYC + 1) else $error("non-fatal code shown too long");
  a_fatal_hold: assert property (
    (disp.mode == DM_ERR && (disp.code == CODE_E100 || disp.code == CODE_E200))
    |=> $stable(disp) && !power_en) else $error("fatal code not held");
  a_b_hold: assert property (
    bvalid && !bready |=> bvalid && $stable(bresp)) else $error("write response dropped");
  a_r_hold: assert property (
    rvalid && !rready |=> rvalid && $stable(rdata)) else $error("read data dropped");
  c_orng: cover property (disp.mode == DM_ORNG);
  c_fault: cover property (disp.mode == DM_ERR && disp.code == 16'h0005);
  c_aux: cover property (aux_out && power_en);
endmodule : tcsup_monitor
`default_nettype wire

//--- tcsup_sensor_model.sv
// Measurement front end model: one reading every eight cycles.
// Assumes the bench sets the temperature to report; between strobes the value toggles.
`default_nettype none
module tcsup_sensor_model (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Temperature to report
  input wire logic signed [15:0] temp_set,
  // Reading
  output logic temp_valid,
  output logic signed [15:0] temp_raw
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] phase_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase_reg <= 3'h0;
    end else begin
      phase_reg <= phase_reg + 3'h1;
    end
  end
  // Value is only meaningful with the strobe
  always_ff @(posedge aclk) begin
    temp_valid <= aresetn && phase_reg == 3'h7;
    temp_raw <= !aresetn ? 16'sh0000 : (phase_reg == 3'h7 ? temp_set : ~temp_raw);
  end
endmodule : tcsup_sensor_model
`default_nettype wire

//--- tb_tcsup_top.sv
// Self-checking bench of the supervisor: AXI4-Lite master, keys, faults, sensor model.
// Assumes the checker and sensor model files are compiled before this one.
`default_nettype none
module tb_tcsup_top
  import tcsup_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, cfg_load_done = 1'b0, cfg_load_ok = 1'b0;
  logic key_wr = 1'b0, aux_in = 1'b0, stack_fault = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, key_addr = 8'h00;
  logic [31:0] wdata = 32'h0, key_val = 32'h0;
  logic [NF_N-1:0] fault_pulse = '0;
  logic signed [15:0] temp_set = 16'sh00c8;
  tcsup_cfg_t cfg_load = '0;
  logic awready, wready, bvalid, arready, rvalid, temp_valid, power_en, aux_out;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic signed [15:0] temp_raw, active_sp;
  tcsup_cfg_t cfg_eff;
  tcsup_disp_t disp;
  int num_errors = 0;
  int comparisons = 0;
  always #25 aclk = ~aclk;
  tcsup_top #(.ERR_SHOW_CYC(20), .RAMP_UNIT_CYC(100)) dut (.aclk, .aresetn, .awvalid, .awready,
    .awaddr, .wvalid, .wready, .wdata, .wstrb(4'hf), .bvalid, .bready, .bresp, .arvalid,
    .arready, .araddr, .rvalid, .rready, .rdata, .rresp, .temp_valid, .temp_raw, .cfg_load_done,
    .cfg_load_ok, .cfg_load, .key_wr, .key_addr, .key_val, .aux_in, .fault_pulse, .stack_fault,
    .cfg_eff, .active_sp, .power_en, .aux_out, .disp);
  tcsup_sensor_model u_sensor (.aclk, .aresetn, .temp_set, .temp_valid, .temp_raw);
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic end_sim();
    $display("comparisons %0d errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_sim
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask : cyc
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    // Ready held back one cycle so the answer must stand
    bready <= 1'b1;
    @(posedge aclk);
    r = bresp;
    bready <= 1'b0;
  endtask : axw
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b1;
    @(posedge aclk);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : axr
  task automatic setc(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axw(a, d, r);
    axw(A_CTRL, 32'h1, r);
    cyc(3);
  endtask : setc
  task automatic t_reset_vals();
    logic [31:0] d;
    logic [1:0] r;
    chk("power_en", power_en, 32'h0);
    chk("disp_mode", disp.mode, DM_TEST);
    axr(A_MODE, d, r);
    chk("mode_rst", d, 32'h1);
    axr(A_DUTY, d, r);
    chk("duty_rst", d, 32'h7f);
    axr(8'h2c, d, r);
    chk("unmapped", r, RESP_ERR);
    axw(A_STAT, 32'h1, r);
    chk("status_wr", r, RESP_ERR);
  endtask : t_reset_vals
  task automatic t_load();
    cfg_load <= '{setpoint: 16'sh00fa, tol_band: 7'h02, alarm_band: 7'h05, filt_sec: 6'h01,
      duty_limit: 7'h7f, ramp_rate: 10'h00a, default: '0};
    cfg_load_ok <= 1'b1;
    cfg_load_done <= 1'b1;
    @(posedge aclk);
    cfg_load_done <= 1'b0;
    do @(posedge aclk); while (!temp_valid);
    cyc(3);
    chk("seed", active_sp, 32'hc8);
    cyc(100);
    chk("ramp", active_sp >= 16'sh00d1 && active_sp <= 16'sh00d3, 32'h1);
    chk("alarm", aux_out, 32'h1);
    chk("power", power_en, 32'h1);
  endtask : t_load
  task automatic t_apply();
    logic [1:0] r;
    axw(A_RAMP, 32'h0, r);
    axw(A_SP, 32'h12c, r);
    chk("disp_bus", disp.mode, DM_TEMP);
    cyc(3);
    chk("sp_held", cfg_eff.setpoint, 32'hfa);
    setc(A_CTRL, 32'h1);
    chk("sp_apply", cfg_eff.setpoint, 32'h12c);
    chk("sp_jump", active_sp, 32'h12c);
  endtask : t_apply
  task automatic t_limits();
    logic [7:0] a [10] = '{A_MODE, A_MODE, A_BAND, A_BAND, A_GAIN, A_ILIM, A_DUTY, A_SP, A_SP,
      A_RAMP};
    logic [31:0] w [10] = '{32'h232, 32'h303, 32'h502, 32'h6463, 32'h403fff, 32'h3e8, 32'h80,
      32'h7d0, 32'hfc21, 32'h3e8};
    logic [31:0] e [10] = '{32'h232, 32'h232, 32'h502, 32'h563, 32'h3f3f3f, 32'h3e7, 32'h0,
      32'h12c, 32'h12c, 32'h0};
    logic [31:0] d;
    logic [1:0] r;
    for (int i = 0; i < 10; i++) begin
      axw(a[i], w[i], r);
      axr(a[i], d, r);
      chk("limit", d, e[i]);
    end
    setc(A_CTRL, 32'h1);
    chk("duty_zero", power_en, 32'h0);
    setc(A_DUTY, 32'h7f);
  endtask : t_limits
  task automatic t_aux();
    logic signed [15:0] pv [4] = '{16'sh00c8, 16'sh00c9, 16'sh0126, 16'sh0127};
    logic signed [15:0] dev;
    for (int m = 0; m < 2; m++) begin
      setc(A_MODE, 32'h232 | (m << 17));
      for (int i = 0; i < 4; i++) begin
        temp_set <= pv[i];
        cyc(20);
        dev = 16'sh012c - pv[i];
        chk("aux_out", aux_out, m ? (dev <= 16'sh0063) : (dev > 16'sh0005));
      end
    end
    for (int m = 0; m < 2; m++) begin
      setc(A_MODE, 32'h232 | (m << 17) | (m << 16));
      aux_in <= 1'b1;
      cyc(4);
      chk("aux_in_hi", power_en, m);
      aux_in <= 1'b0;
      cyc(4);
      chk("aux_in_lo", power_en, 1 - m);
    end
    setc(A_MODE, 32'h232);
  endtask : t_aux
  task automatic t_orng();
    logic signed [15:0] bad [2] = '{16'sh06d7, 16'shfd11};
    logic signed [15:0] edg [2] = '{16'sh06d6, 16'shfd12};
    logic [31:0] d;
    logic [1:0] r;
    for (int i = 0; i < 2; i++) begin
      temp_set <= bad[i];
      cyc(20);
      chk("orng_code", {disp.blink, disp.code}, {1'b1, CODE_ORNG});
      chk("orng_power", power_en, 32'h0);
      if (i == 0) begin
        axr(A_STAT, d, r);
        chk("stat_orng", d, 32'h012c0033);
        axr(A_DISP, d, r);
        chk("disp_orng", d, {13'h0, 1'b1, DM_ORNG, CODE_ORNG});
      end
      temp_set <= edg[i];
      cyc(20);
      chk("orng_back", disp.mode, DM_TEMP);
      chk("back_power", power_en, 32'h1);
    end
    temp_set <= 16'sh012c;
    cyc(20);
  endtask : t_orng
  task automatic t_fault();
    for (int i = 0; i < NF_N; i++) begin
      fault_pulse <= 5'h01 << i;
      @(posedge aclk);
      fault_pulse <= '0;
      cyc(2);
      chk("fault_code", {disp.blink, disp.code}, i + 1);
      chk("fault_power", power_en, 32'h0);
      cyc(25);
      chk("fault_end", disp.mode, DM_TEMP);
    end
  endtask : t_fault
  task automatic key_at_pulse(input logic [31:0] v);
    do @(posedge aclk); while (!temp_valid);
    cyc(7);
    key_addr <= A_OFFS;
    key_val <= v;
    key_wr <= 1'b1;
    @(posedge aclk);
    key_wr <= 1'b0;
  endtask : key_at_pulse
  task automatic t_offset();
    key_at_pulse(32'h131);
    cyc(2);
    chk("key_offs", cfg_eff.offset, 32'h5);
    key_at_pulse(32'h12c);
    cyc(2);
    chk("key_keep", cfg_eff.offset, 32'h5);
    setc(A_OFFS, 32'h0);
    chk("host_clear", cfg_eff.offset, 32'h0);
  endtask : t_offset
  task automatic t_fatal();
    stack_fault <= 1'b1;
    @(posedge aclk);
    stack_fault <= 1'b0;
    cyc(40);
    chk("stack", {disp.code, 15'h0, power_en}, {CODE_E200, 16'h0});
    aresetn <= 1'b0;
    cfg_load_ok <= 1'b0;
    cyc(10);
    aresetn <= 1'b1;
    cfg_load_done <= 1'b1;
    @(posedge aclk);
    cfg_load_done <= 1'b0;
    cyc(40);
    chk("no_config", {disp.code, 15'h0, power_en}, {CODE_E100, 16'h0});
  endtask : t_fatal
  initial begin
    cyc(10);
    aresetn <= 1'b1;
    cyc(2);
    t_reset_vals();
    t_load();
    t_apply();
    t_limits();
    t_aux();
    t_orng();
    t_fault();
    t_offset();
    t_fatal();
    end_sim();
  end
  initial begin
    #1000000;
    num_errors++;
    end_sim();
  end
endmodule : tb_tcsup_top
bind tcsup_top tcsup_monitor #(.ERR_SHOW_CYC(ERR_SHOW_CYC), .RAMP_UNIT_CYC(RAMP_UNIT_CYC)) u_mon (
  .aclk, .aresetn, .bvalid, .bready, .bresp, .rvalid, .rready, .rdata, .temp_valid, .temp_raw,
  .aux_in, .fault_pulse, .cfg_eff, .power_en, .aux_out, .disp);
`default_nettype wire
